/* core/vsd_pkg.sv */
package vsd_pkg;

  // ----------------------------------------
  // bus and window geometry
  // ----------------------------------------
  localparam int DW = 32;
  localparam int OFS_W = 11;
  localparam int BASE_W = 21;
  localparam int BASE_LO = 11;

  typedef logic [OFS_W-1:0] vsd_ofs_t;

  localparam vsd_ofs_t OFS_CSR = 11'h000;
  localparam vsd_ofs_t OFS_ID = 11'h004;
  localparam vsd_ofs_t OFS_COPY = 11'h00C;
  localparam vsd_ofs_t OFS_FTEST = 11'h010;
  localparam vsd_ofs_t OFS_CLR = 11'h020;
  localparam vsd_ofs_t OFS_SWNEXT = 11'h024;
  localparam vsd_ofs_t OFS_NXON = 11'h028;
  localparam vsd_ofs_t OFS_NXOFF = 11'h02C;
  localparam vsd_ofs_t OFS_REFON = 11'h050;
  localparam vsd_ofs_t OFS_REFOFF = 11'h054;
  localparam vsd_ofs_t OFS_ROAK = 11'h058;
  localparam vsd_ofs_t OFS_RORA = 11'h05C;
  localparam vsd_ofs_t OFS_GRST = 11'h060;
  localparam vsd_ofs_t OFS_TPULSE = 11'h068;
  localparam vsd_ofs_t OFS_PRESC = 11'h080;
  localparam vsd_ofs_t OFS_FIFO_LO = 11'h100;
  localparam vsd_ofs_t OFS_FIFO_HI = 11'h1FC;

  // ----------------------------------------
  // address modes
  // ----------------------------------------
  localparam logic [1:0] AM_A32 = 2'h0;
  localparam logic [1:0] AM_A16 = 2'h2;
  localparam logic [1:0] AM_A24 = 2'h3;
  localparam logic [BASE_W-1:0] MASK_A32 = 21'h1FFFFF;
  localparam logic [BASE_W-1:0] MASK_A24 = 21'h001FFF;
  localparam logic [BASE_W-1:0] MASK_A16 = 21'h00001F;

  // ----------------------------------------
  // status and control layout
  // ----------------------------------------
  localparam int ST_IRQ_LO = 28;
  localparam int ST_ROAK = 25;
  localparam int ST_HI_LO = 16;
  localparam int ST_NEXT = 15;
  localparam int ST_REF = 13;
  localparam int ST_FLAG_LO = 8;
  localparam int CFG_W = 16;
  localparam int CFG_FTEST = 1;
  localparam int CFG_EXT_NEXT = 8;
  localparam int CFG_SWDIS = 11;
  localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
  localparam int IRQ_W = 12;
  localparam int PRESC_W = 28;
  // arbitrary identity value
  localparam logic [19:0] ID_CODE = 20'h5A001;

  // ----------------------------------------
  // fifo
  // ----------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W = 5;
  localparam logic [LVL_W-1:0] LVL_FULL = 5'h10;
  localparam logic [LVL_W-1:0] LVL_AF = 5'h0C;
  localparam logic [LVL_W-1:0] LVL_HF = 5'h08;
  localparam logic [LVL_W-1:0] LVL_AE = 5'h04;
  localparam logic LARGE_FIFO = 1'b0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int STRETCH_MS = 50;
  localparam int STRETCH_CYC = STRETCH_MS * (CLK_HZ / 1000);
  localparam int STR_W = 20;

  // ----------------------------------------
  // synchroniser lanes
  // ----------------------------------------
  localparam int SY_AS = 0;
  localparam int SY_DS = 1;
  localparam int SY_WR = 2;
  localparam int SY_NEXT = 3;
  localparam int SY_CIP = 4;
  localparam int SY_SW_LO = 5;
  localparam int SY_J11 = 25;
  localparam int SY_LONG = 26;
  localparam int SY_STD = 27;
  localparam int SY_SHORT = 28;
  localparam int IN_W = 29;
  localparam logic [IN_W-1:0] SY_RST = 29'h00000007;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DECODE = 2'b01,
    ST_ACK = 2'b10,
    ST_HOLD = 2'b11
  } vsd_bus_state_t;

endpackage

/* core/vsd_fifo_if.sv */
`timescale 1ns/100ps
interface vsd_fifo_if #(parameter int W = 32, parameter int LW = 5);
  logic clear;
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  logic [LW-1:0] level;

  modport fifo (
    input clear, wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data, level
  );
  modport user (
    output clear, wr_valid, wr_data, rd_ready,
    input wr_ready, rd_valid, rd_data, level
  );
endinterface

/* core/vsd_fifo.sv */
`timescale 1ns/100ps
module vsd_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // buffer ports
  vsd_fifo_if.fifo port
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
  } vsd_fifo_state_t;

  vsd_fifo_state_t s;
  vsd_fifo_state_t n;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign port.wr_ready = (s.count != (PW+1)'(DEPTH));
  assign port.rd_valid = (s.count != '0);
  assign port.rd_data = mem[s.rptr];
  assign port.level = s.count;

  always_comb begin
    n = s;
    push = port.wr_valid & port.wr_ready;
    pop = port.rd_ready & port.rd_valid;
    if (push) begin
      n.wptr = s.wptr + 1'b1;
    end
    if (pop) begin
      n.rptr = s.rptr + 1'b1;
    end
    n.count = s.count + (PW+1)'(push) - (PW+1)'(pop);
    // clear beats any transfer of the same cycle
    if (port.clear) begin
      n = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push && !port.clear) begin
      mem[s.wptr] <= port.wr_data;
    end
  end

endmodule

/* core/vsd_top.sv */
`timescale 1ns/100ps
module vsd_top
  import vsd_pkg::*;
#(
  parameter int STRETCH_CYCLES = STRETCH_CYC
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  // vme slave
  input wire logic [31:0] VME_ADDR_I,
  input wire logic [5:0] VME_AM_I,
  input wire logic VME_AS_B_I,
  input wire logic VME_DS_B_I,
  input wire logic VME_WRITE_B_I,
  input wire logic [31:0] VME_DATA_I,
  output logic [31:0] VME_DATA_O,
  output logic VME_DATA_OE_O,
  output logic VME_DTACK_OE_O,
  // base address straps, high when a jumper is open
  input wire logic [3:0] ADDR_NIBBLE_31_28_SWITCH_I,
  input wire logic [3:0] ADDR_NIBBLE_27_24_SWITCH_I,
  input wire logic [3:0] ADDR_NIBBLE_23_20_SWITCH_I,
  input wire logic [3:0] ADDR_NIBBLE_19_16_SWITCH_I,
  input wire logic [3:0] ADDR_NIBBLE_15_12_SWITCH_I,
  input wire logic ADDR_BIT11_JUMPER_I,
  input wire logic LONG_ADDR_MODE_JUMPER_I,
  input wire logic STANDARD_ADDR_MODE_JUMPER_I,
  input wire logic SHORT_ADDR_MODE_JUMPER_I,
  // acquisition side
  input wire logic EXT_NEXT_I,
  input wire logic COPY_IN_PROGRESS_I,
  input wire logic [31:0] ACQ_DATA_I,
  input wire logic ACQ_VALID_I,
  output logic ACQ_READY_O,
  // settings towards the counters
  output logic [CFG_W-1:0] CONFIG_O,
  output logic [31:0] COPY_MASK_O,
  output logic [PRESC_W-1:0] PRESCALE_FACTOR_O,
  output logic [IRQ_W-1:0] IRQ_CONTROL_O,
  output logic REF_PULSER_O,
  output logic IRQ_ROAK_O,
  output logic COUNT_RUN_O,
  // one-cycle strobes
  output logic CLEAR_ALL_O,
  output logic NEXT_PULSE_O,
  output logic TEST_PULSE_O,
  // front panel indicators
  output logic LED_ACCESS_O,
  output logic LED_CLEAR_O,
  output logic LED_SCALER_O,
  output logic LED_USER_O,
  output logic LED_CIP_O
);

  typedef struct packed {
    logic [IN_W-1:0] sy1;
    logic [IN_W-1:0] sy2;
    logic [IN_W-1:0] sy3;
    logic [IN_W-1:0] stab;
    vsd_bus_state_t bus;
    logic addr_held;
    logic [31:0] addr;
    logic [5:0] am;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic dtack;
    logic oe;
    logic [CFG_W-1:0] cfg;
    logic next_en;
    logic started;
    logic ref_en;
    logic roak;
    logic [31:0] copy_mask;
    logic [IRQ_W-1:0] irq_ctl;
    logic [PRESC_W-1:0] presc;
    logic full_seen;
    logic ext_q;
    logic clear_p;
    logic next_p;
    logic test_p;
    logic [2:0][STR_W-1:0] stretch;
  } vsd_top_state_t;

  vsd_top_state_t s;
  vsd_top_state_t n;

  vsd_fifo_if #(.W(DW), .LW(LVL_W)) fif ();

  logic [IN_W-1:0] in_vec;
  logic [IN_W-1:0] agree;
  logic hit;
  logic dec;
  vsd_ofs_t ofs;
  logic fifo_win;
  logic sw_next;
  logic ext_edge;
  logic test_push;
  logic rd_pop;
  logic f_full;
  logic f_af;
  logic f_hf;
  logic f_ae;
  logic f_empty;
  logic run;
  logic [2:0] trig;
  logic [31:0] status;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic addr_hit(input logic [31:0] a, input logic [5:0] am,
                                    input logic [IN_W-1:0] st);
    logic [BASE_W-1:0] base;
    logic [BASE_W-1:0] mask;
    logic en;
    // jumper pin reads high when open, so open gives a one
    base = {st[SY_SW_LO +: 20], st[SY_J11]};
    mask = '0;
    en = 1'b0;
    case (am[5:4])
      AM_A32: begin
        mask = MASK_A32;
        en = ~st[SY_LONG];
      end
      AM_A24: begin
        mask = MASK_A24;
        en = ~st[SY_STD];
      end
      AM_A16: begin
        mask = MASK_A16;
        en = ~st[SY_SHORT];
      end
      default: begin
        mask = '0;
        en = 1'b0;
      end
    endcase
    // low eleven bits are the 2 KB offset and never compared
    return en && (((a[31:BASE_LO] ^ base) & mask) == '0);
  endfunction

  function automatic logic [CFG_W-1:0] jk(input logic [CFG_W-1:0] old,
                                          input logic [31:0] d);
    logic [CFG_W-1:0] set;
    logic [CFG_W-1:0] clr;
    set = {d[23:16], d[7:0]};
    clr = {d[31:24], d[15:8]};
    // both bits at once is undefined by contract; set wins here
    return (old & ~clr) | set;
  endfunction

  // ----------------------------------------
  // fifo flags and status word
  // ----------------------------------------
  assign f_full = (fif.level == LVL_FULL);
  assign f_af = (fif.level >= LVL_AF);
  assign f_hf = (fif.level >= LVL_HF);
  assign f_ae = (fif.level <= LVL_AE);
  assign f_empty = (fif.level == '0);

  always_comb begin
    status = '0;
    status[ST_IRQ_LO +: 4] = {f_af, f_hf, f_full, s.stab[SY_CIP]};
    status[ST_ROAK] = s.roak;
    status[ST_HI_LO +: 8] = s.cfg[15:8];
    status[ST_NEXT] = s.next_en;
    status[ST_REF] = s.ref_en;
    status[ST_FLAG_LO +: 5] = {f_full, f_af, f_hf, f_ae ^ LARGE_FIFO, f_empty};
    status[7:0] = s.cfg[7:0];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = s;
    n.clear_p = 1'b0;
    n.next_p = 1'b0;
    n.test_p = 1'b0;
    in_vec = {SHORT_ADDR_MODE_JUMPER_I, STANDARD_ADDR_MODE_JUMPER_I,
              LONG_ADDR_MODE_JUMPER_I, ADDR_BIT11_JUMPER_I,
              ADDR_NIBBLE_31_28_SWITCH_I, ADDR_NIBBLE_27_24_SWITCH_I,
              ADDR_NIBBLE_23_20_SWITCH_I, ADDR_NIBBLE_19_16_SWITCH_I,
              ADDR_NIBBLE_15_12_SWITCH_I, COPY_IN_PROGRESS_I, EXT_NEXT_I,
              VME_WRITE_B_I, VME_DS_B_I, VME_AS_B_I};
    n.sy1 = in_vec;
    n.sy2 = s.sy1;
    n.sy3 = s.sy2;
    // a lane moves only once the last two stages agree
    agree = ~(s.sy2 ^ s.sy3);
    n.stab = (s.stab & ~agree) | (s.sy3 & agree);
    hit = addr_hit(s.addr, s.am, s.stab);
    ofs = s.addr[OFS_W-1:0];
    fifo_win = (ofs >= OFS_FIFO_LO) && (ofs <= OFS_FIFO_HI);
    dec = (s.bus == ST_DECODE) && hit;
    sw_next = 1'b0;
    test_push = 1'b0;
    rd_pop = 1'b0;
    if (s.stab[SY_AS]) begin
      n.addr_held = 1'b0;
    end

    // bus handshake; address is kept across a block transfer
    case (s.bus)
      ST_IDLE: begin
        if (!s.stab[SY_AS] && !s.stab[SY_DS]) begin
          if (!s.addr_held) begin
            n.addr = VME_ADDR_I;
            n.am = VME_AM_I;
            n.addr_held = 1'b1;
          end
          n.wr = ~s.stab[SY_WR];
          n.wdata = VME_DATA_I;
          n.bus = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (hit) begin
          n.dtack = 1'b1;
          n.oe = ~s.wr;
          n.bus = ST_ACK;
        end else begin
          n.bus = ST_HOLD;
        end
      end
      ST_ACK, ST_HOLD: begin
        if (s.stab[SY_DS]) begin
          n.dtack = 1'b0;
          n.oe = 1'b0;
          n.bus = ST_IDLE;
        end
      end
      default: begin
        n.bus = ST_IDLE;
      end
    endcase

    // reads
    if (dec && !s.wr) begin
      n.rdata = '0;
      if (ofs == OFS_CSR) begin
        n.rdata = status;
      end else if (ofs == OFS_ID) begin
        n.rdata = {ID_CODE, s.irq_ctl};
      end else if (ofs == OFS_PRESC) begin
        n.rdata = {4'h0, s.presc};
      end else if (fifo_win) begin
        // empty fifo reads as zero rather than stalling the bus
        rd_pop = fif.rd_valid;
        n.rdata = fif.rd_valid ? fif.rd_data : '0;
      end
    end

    // writes; key offsets never look at the data
    if (dec && s.wr) begin
      case (ofs)
        OFS_CSR: n.cfg = jk(s.cfg, s.wdata);
        OFS_ID: n.irq_ctl = s.wdata[IRQ_W-1:0];
        OFS_COPY: n.copy_mask = s.wdata;
        OFS_FTEST: test_push = s.cfg[CFG_FTEST];
        OFS_CLR: begin
          n.clear_p = 1'b1;
          n.started = 1'b0;
        end
        OFS_SWNEXT: sw_next = 1'b1;
        OFS_NXON: n.next_en = 1'b1;
        OFS_NXOFF: begin
          n.next_en = 1'b0;
          n.started = 1'b0;
        end
        OFS_REFON: n.ref_en = 1'b1;
        OFS_REFOFF: n.ref_en = 1'b0;
        OFS_ROAK: n.roak = 1'b1;
        OFS_RORA: n.roak = 1'b0;
        OFS_TPULSE: n.test_p = 1'b1;
        OFS_PRESC: n.presc = s.wdata[PRESC_W-1:0];
        OFS_GRST: begin
          n.cfg = CFG_RST;
          n.next_en = 1'b0;
          n.started = 1'b0;
          n.ref_en = 1'b0;
          n.roak = 1'b0;
          n.copy_mask = '0;
          n.irq_ctl = '0;
          n.presc = '0;
          n.clear_p = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // first next pulse only arms counting; later ones switch banks
    n.ext_q = s.stab[SY_NEXT];
    ext_edge = s.cfg[CFG_EXT_NEXT] & s.stab[SY_NEXT] & ~s.ext_q;
    if (s.next_en && (sw_next || ext_edge)) begin
      if (s.started) begin
        n.next_p = 1'b1;
      end else begin
        n.started = 1'b1;
      end
    end

    // a full fifo blocks acquisition until the next clear
    if (s.clear_p) begin
      n.full_seen = 1'b0;
    end
    if (f_full && !s.clear_p) begin
      n.full_seen = 1'b1;
    end

    // indicator stretch
    run = s.started & ~s.cfg[CFG_SWDIS];
    trig = {run, s.clear_p, s.dtack};
    for (int i = 0; i < 3; i++) begin
      if (trig[i]) begin
        n.stretch[i] = STR_W'(STRETCH_CYCLES - 1);
      end else if (s.stretch[i] != '0) begin
        n.stretch[i] = s.stretch[i] - 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s <= '0;
      s.sy1 <= SY_RST;
      s.sy2 <= SY_RST;
      s.sy3 <= SY_RST;
      s.stab <= SY_RST;
      s.bus <= ST_IDLE;
      s.cfg <= CFG_RST;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // fifo path
  // ----------------------------------------
  assign fif.clear = s.clear_p;
  assign fif.wr_valid = test_push | (ACQ_VALID_I & ~s.full_seen);
  assign fif.wr_data = test_push ? s.wdata : ACQ_DATA_I;
  assign fif.rd_ready = rd_pop;
  assign ACQ_READY_O = fif.wr_ready & ~test_push & ~s.full_seen;

  vsd_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .port(fif)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign VME_DATA_O = s.rdata;
  assign VME_DATA_OE_O = s.oe;
  assign VME_DTACK_OE_O = s.dtack;
  assign CONFIG_O = s.cfg;
  assign COPY_MASK_O = s.copy_mask;
  assign PRESCALE_FACTOR_O = s.presc;
  assign IRQ_CONTROL_O = s.irq_ctl;
  assign REF_PULSER_O = s.ref_en;
  assign IRQ_ROAK_O = s.roak;
  assign COUNT_RUN_O = s.started & ~s.cfg[CFG_SWDIS];
  assign CLEAR_ALL_O = s.clear_p;
  assign NEXT_PULSE_O = s.next_p;
  assign TEST_PULSE_O = s.test_p;
  assign LED_ACCESS_O = (s.stretch[0] != '0);
  assign LED_CLEAR_O = (s.stretch[1] != '0);
  assign LED_SCALER_O = (s.stretch[2] != '0);
  assign LED_USER_O = s.cfg[0];
  assign LED_CIP_O = s.stab[SY_CIP];

endmodule

/* bench/vsd_top_monitor.sv */
`timescale 1ns/100ps
module vsd_top_monitor
  import vsd_pkg::*;
#(
  parameter int STRETCH_CYCLES = STRETCH_CYC
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  // bus
  input wire logic VME_DS_B_I,
  input wire logic VME_WRITE_B_I,
  input wire logic VME_DATA_OE_O,
  input wire logic VME_DTACK_OE_O,
  // control side
  input wire logic [CFG_W-1:0] CONFIG_O,
  input wire logic COUNT_RUN_O,
  input wire logic CLEAR_ALL_O,
  input wire logic NEXT_PULSE_O,
  input wire logic TEST_PULSE_O,
  input wire logic LED_CLEAR_O,
  input wire logic LED_USER_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_B_I);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_wr_ack;
    VME_DTACK_OE_O && !VME_WRITE_B_I;
  endsequence
  sequence s_led_on;
    LED_CLEAR_O [*4];
  endsequence

  // lit cycles since the last clear; a stuck lamp would grow this
  int lit_q;
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      lit_q <= 0;
    end else if (CLEAR_ALL_O || !LED_CLEAR_O) begin
      lit_q <= 0;
    end else begin
      lit_q <= lit_q + 1;
    end
  end

  tpulse_single_a: assert property (TEST_PULSE_O |=> !TEST_PULSE_O)
    else $error("test pulse longer than one cycle");
  tpulse_cause_a: assert property ($rose(TEST_PULSE_O) |-> s_wr_ack)
    else $error("test pulse without a write acknowledge");
  clear_cause_a: assert property ($rose(CLEAR_ALL_O) |-> s_wr_ack)
    else $error("clear pulse without a write acknowledge");
  clear_led_a: assert property (CLEAR_ALL_O |-> ##[1:2] s_led_on)
    else $error("clear lamp not stretched");
  lamp_span_a: assert property (lit_q <= STRETCH_CYCLES + 2)
    else $error("clear lamp lit too long");
  user_led_a: assert property (LED_USER_O == CONFIG_O[0])
    else $error("user lamp differs from its control bit");
  count_gate_a: assert property (COUNT_RUN_O |-> !CONFIG_O[CFG_SWDIS])
    else $error("counting while software disable set");
  first_next_a: assert property ($rose(COUNT_RUN_O) && !$past(CONFIG_O[CFG_SWDIS]) |-> !NEXT_PULSE_O)
    else $error("first next pulse produced a bank switch");
  ack_hold_a: assert property (VME_DTACK_OE_O && !VME_DS_B_I |=> VME_DTACK_OE_O)
    else $error("acknowledge dropped while strobe low");
  ack_release_a: assert property ($rose(VME_DS_B_I) |-> ##[0:8] !VME_DTACK_OE_O)
    else $error("acknowledge not released");
  read_drive_a: assert property (VME_DATA_OE_O |-> VME_WRITE_B_I && VME_DTACK_OE_O)
    else $error("data driven outside a read acknowledge");
endmodule

bind vsd_top vsd_top_monitor #(.STRETCH_CYCLES(STRETCH_CYCLES)) vsd_top_monitor_i (
  .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .VME_DS_B_I(VME_DS_B_I),
  .VME_WRITE_B_I(VME_WRITE_B_I), .VME_DATA_OE_O(VME_DATA_OE_O),
  .VME_DTACK_OE_O(VME_DTACK_OE_O), .CONFIG_O(CONFIG_O), .COUNT_RUN_O(COUNT_RUN_O),
  .CLEAR_ALL_O(CLEAR_ALL_O), .NEXT_PULSE_O(NEXT_PULSE_O), .TEST_PULSE_O(TEST_PULSE_O),
  .LED_CLEAR_O(LED_CLEAR_O), .LED_USER_O(LED_USER_O)
);

/* bench/vsd_vme_master.sv */
`timescale 1ns/100ps
module vsd_vme_master (
  // clock and slave answer
  input wire logic clk_i,
  input wire logic dtack_oe_i,
  input wire logic [31:0] rdata_i,
  // master drive
  output logic [31:0] addr_o,
  output logic [5:0] am_o,
  output logic as_b_o,
  output logic ds_b_o,
  output logic write_b_o,
  output logic [31:0] wdata_o
);
  logic [31:0] rq[$];
  logic acked;

  initial begin
    addr_o = 32'h0;
    am_o = 6'h3F;
    as_b_o = 1'b1;
    ds_b_o = 1'b1;
    write_b_o = 1'b1;
    wdata_o = 32'h0;
    acked = 1'b0;
  end

  // n strobes under one address strobe; released address, modifier and data lines show inverted values
  task automatic xfer(input logic [31:0] a, input logic [5:0] m, input logic w,
                      input logic [31:0] d, input int n);
    int k;
    acked = 1'b0;
    @(negedge clk_i);
    addr_o = a;
    am_o = m;
    write_b_o = ~w;
    wdata_o = d;
    as_b_o = 1'b0;
    repeat (n) begin
      @(negedge clk_i);
      ds_b_o = 1'b0;
      for (k = 0; k < 30 && dtack_oe_i !== 1'b1; k++) @(posedge clk_i);
      if (dtack_oe_i === 1'b1) begin
        acked = 1'b1;
        if (!w) rq.push_back(rdata_i);
      end
      @(negedge clk_i);
      ds_b_o = 1'b1;
      for (k = 0; k < 30 && dtack_oe_i !== 1'b0; k++) @(posedge clk_i);
    end
    @(negedge clk_i);
    as_b_o = 1'b1;
    write_b_o = 1'b1;
    addr_o = ~a;
    am_o = ~m;
    wdata_o = ~d;
    // address strobe must stay high long enough to pass the synchroniser
    repeat (4) @(negedge clk_i);
  endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/100ps
module tb;
  import vsd_pkg::*;
  localparam logic [31:0] BASE = 32'h38383800;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] addr, wdata, rdata;
  logic [5:0] am;
  logic as_b, ds_b, wr_b, dtack, acq_valid = 1'b0, ext_next = 1'b0, copy_in_progress = 1'b0;
  logic [19:0] sw = 20'h38383;
  logic j11 = 1'b1, jshort = 1'b0;
  logic [31:0] acq_data = 32'h0;
  int n_fail = 0, compares = 0, tp_n = 0, nx_n = 0, clr_n = 0;

  always #25 clk = ~clk;

  vsd_top #(.STRETCH_CYCLES(8)) vsd_top_i (
    .CLOCK_I(clk), .RST_B_I(rst_b), .VME_ADDR_I(addr), .VME_AM_I(am),
    .VME_AS_B_I(as_b), .VME_DS_B_I(ds_b), .VME_WRITE_B_I(wr_b),
    .VME_DATA_I(wdata), .VME_DATA_O(rdata), .VME_DATA_OE_O(), .VME_DTACK_OE_O(dtack),
    .ADDR_NIBBLE_31_28_SWITCH_I(sw[19:16]), .ADDR_NIBBLE_27_24_SWITCH_I(sw[15:12]),
    .ADDR_NIBBLE_23_20_SWITCH_I(sw[11:8]), .ADDR_NIBBLE_19_16_SWITCH_I(sw[7:4]),
    .ADDR_NIBBLE_15_12_SWITCH_I(sw[3:0]), .ADDR_BIT11_JUMPER_I(j11),
    .LONG_ADDR_MODE_JUMPER_I(1'b0), .STANDARD_ADDR_MODE_JUMPER_I(1'b0),
    .SHORT_ADDR_MODE_JUMPER_I(jshort), .EXT_NEXT_I(ext_next),
    .COPY_IN_PROGRESS_I(copy_in_progress), .ACQ_DATA_I(acq_data), .ACQ_VALID_I(acq_valid),
    .ACQ_READY_O(), .CONFIG_O(), .COPY_MASK_O(), .PRESCALE_FACTOR_O(),
    .IRQ_CONTROL_O(), .REF_PULSER_O(), .IRQ_ROAK_O(), .COUNT_RUN_O(), .CLEAR_ALL_O(),
    .NEXT_PULSE_O(), .TEST_PULSE_O(), .LED_ACCESS_O(), .LED_CLEAR_O(), .LED_SCALER_O(),
    .LED_USER_O(), .LED_CIP_O()
  );

  vsd_vme_master vsd_vme_master_i (
    .clk_i(clk), .dtack_oe_i(dtack), .rdata_i(rdata), .addr_o(addr), .am_o(am),
    .as_b_o(as_b), .ds_b_o(ds_b), .write_b_o(wr_b), .wdata_o(wdata)
  );

  always @(posedge clk) begin
    if (vsd_top_i.TEST_PULSE_O === 1'b1) tp_n <= tp_n + 1;
    if (vsd_top_i.NEXT_PULSE_O === 1'b1) nx_n <= nx_n + 1;
    if (vsd_top_i.CLEAR_ALL_O === 1'b1) clr_n <= clr_n + 1;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR at %0t: got 0x%h expected 0x%h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk32({31'h0, g}, {31'h0, e});
  endtask
  task automatic wr(input vsd_ofs_t o, input logic [31:0] d);
    vsd_vme_master_i.xfer(BASE | {21'h0, o}, 6'h09, 1'b1, d, 1);
  endtask
  task automatic rd(input vsd_ofs_t o, output logic [31:0] q);
    vsd_vme_master_i.xfer(BASE | {21'h0, o}, 6'h09, 1'b0, 32'h0, 1);
    q = vsd_vme_master_i.acked ? vsd_vme_master_i.rq.pop_front() : 32'hX;
  endtask
  task automatic st(input logic [31:0] e);
    logic [31:0] q;
    rd(OFS_CSR, q);
    chk32(q, e);
  endtask
  task automatic ac(input logic [31:0] a, input logic [5:0] m, input logic e);
    vsd_vme_master_i.xfer(a, m, 1'b0, 32'h0, 1);
    chkb(vsd_vme_master_i.acked, e);
    if (vsd_vme_master_i.acked) void'(vsd_vme_master_i.rq.pop_front());
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_led();
    st(32'h300);
    wr(OFS_CSR, 32'h1);
    chkb(vsd_top_i.LED_USER_O, 1'b1);
    st(32'h301);
    wr(OFS_CSR, 32'h100);
    chkb(vsd_top_i.LED_USER_O, 1'b0);
  endtask
  task automatic t_keys();
    vsd_ofs_t ko[6] = '{OFS_NXON, OFS_NXOFF, OFS_REFON, OFS_REFOFF, OFS_ROAK, OFS_RORA};
    logic [31:0] ke[6] = '{32'h8300, 32'h300, 32'h2300, 32'h300, 32'h2000300, 32'h300};
    int n0;
    for (int i = 0; i < 6; i++) begin
      wr(ko[i], 32'hFFFFFFFF);
      st(ke[i]);
      chkb(vsd_top_i.REF_PULSER_O, ke[i][13]);
      chkb(vsd_top_i.IRQ_ROAK_O, ke[i][25]);
    end
    n0 = tp_n;
    wr(OFS_TPULSE, 32'h0);
    chk32(tp_n - n0, 32'h1);
  endtask
  task automatic t_next();
    int n0;
    n0 = nx_n;
    wr(OFS_NXON, 32'h0);
    wr(OFS_SWNEXT, 32'h0);
    chkb(vsd_top_i.COUNT_RUN_O, 1'b1);
    chkb(vsd_top_i.LED_SCALER_O, 1'b1);
    chk32(nx_n - n0, 32'h0);
    wr(OFS_SWNEXT, 32'h0);
    chk32(nx_n - n0, 32'h1);
    wr(OFS_CSR, 32'h10000);
    st(32'h18300);
    ext_next = 1'b1;
    repeat (6) @(negedge clk);
    ext_next = 1'b0;
    repeat (6) @(negedge clk);
    chk32(nx_n - n0, 32'h2);
    wr(OFS_CSR, 32'h80000);
    chkb(vsd_top_i.COUNT_RUN_O, 1'b0);
    st(32'h98300);
    wr(OFS_CSR, 32'h9000000);
    wr(OFS_NXOFF, 32'h0);
    chkb(vsd_top_i.COUNT_RUN_O, 1'b0);
  endtask
  task automatic t_fifo();
    logic [31:0] q;
    int n0;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      acq_valid = 1'b1;
      acq_data = 32'hA5000000 | i;
      @(posedge clk);
    end
    @(negedge clk);
    acq_valid = 1'b0;
    chkb(vsd_top_i.ACQ_READY_O, 1'b0);
    st(32'hE0001C00);
    vsd_vme_master_i.xfer(BASE | 32'h100, 6'h09, 1'b0, 32'h0, 2);
    chk32(vsd_vme_master_i.rq.pop_front(), 32'hA5000000);
    chk32(vsd_vme_master_i.rq.pop_front(), 32'hA5000001);
    rd(OFS_FIFO_HI, q);
    chk32(q, 32'hA5000002);
    st(32'hC0000C00);
    n0 = clr_n;
    wr(OFS_CLR, 32'hFFFF);
    chk32(clr_n - n0, 32'h1);
    st(32'h300);
    wr(OFS_FTEST, 32'h12345678);
    st(32'h300);
    wr(OFS_CSR, 32'h2);
    wr(OFS_FTEST, 32'h12345678);
    rd(11'h104, q);
    chk32(q, 32'h12345678);
    rd(11'h104, q);
    chk32(q, 32'h0);
    wr(OFS_CSR, 32'h200);
  endtask
  task automatic t_addr();
    logic [31:0] q;
    ac(32'h39383800, 6'h39, 1'b1);
    ac(32'h00003800, 6'h29, 1'b1);
    ac(32'h00003800, 6'h19, 1'b0);
    ac(32'h48383800, 6'h09, 1'b0);
    ac(32'h38384000, 6'h09, 1'b0);
    ac(32'h38383000, 6'h09, 1'b0);
    j11 = 1'b0;
    jshort = 1'b1;
    repeat (6) @(negedge clk);
    ac(32'h38383000, 6'h09, 1'b1);
    ac(32'h00003000, 6'h29, 1'b0);
    j11 = 1'b1;
    jshort = 1'b0;
    repeat (6) @(negedge clk);
    rd(11'h7FC, q);
    chk32(q, 32'h0);
  endtask
  task automatic t_grst();
    int n0;
    wr(OFS_CSR, 32'h1);
    wr(OFS_REFON, 32'h0);
    copy_in_progress = 1'b1;
    n0 = clr_n;
    wr(OFS_GRST, 32'h0);
    st(32'h10000300);
    chkb(vsd_top_i.LED_USER_O, 1'b0);
    chkb(vsd_top_i.REF_PULSER_O, 1'b0);
    chk32(clr_n - n0, 32'h1);
    chk32(vsd_top_i.COPY_MASK_O, 32'h0);
    chkb(vsd_top_i.LED_CIP_O, 1'b1);
    copy_in_progress = 1'b0;
  endtask

  task automatic t_regs();
    logic [31:0] q;
    wr(OFS_COPY, 32'h10);
    chk32(vsd_top_i.COPY_MASK_O, 32'h10);
    wr(OFS_PRESC, 32'hF000270F);
    chk32({4'h0, vsd_top_i.PRESCALE_FACTOR_O}, 32'h0000270F);
    rd(OFS_PRESC, q);
    chk32(q, 32'h0000270F);
    wr(OFS_ID, 32'hFFFFFABC);
    chk32({20'h0, vsd_top_i.IRQ_CONTROL_O}, 32'h00000ABC);
    rd(OFS_ID, q);
    chk32(q, {ID_CODE, 12'hABC});
    chkb(vsd_top_i.LED_ACCESS_O, 1'b1);
    repeat (10) @(negedge clk);
    chkb(vsd_top_i.LED_ACCESS_O, 1'b0);
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_led();
    t_keys();
    t_next();
    t_fifo();
    t_addr();
    t_regs();
    t_grst();
    give_verdict();
  end

  // about twenty thousand cycles, far beyond the sequence above
  initial begin
    #1000000;
    n_fail++;
    give_verdict();
  end
endmodule
